// *** design/wcmd_consts.svh ***
// Purpose: Constants for the write-family command decoder.
// Assumes: Task-file fields arrive already assembled by the link layer.
// Notes:   Opcodes, reset values, last word index of a sector and error codes.
`ifndef WCMD_CONSTS_SVH
`define WCMD_CONSTS_SVH
`define OP_WR_DMA_A    8'hCA
`define OP_WR_DMA_B    8'hCB
`define OP_WR_DMA_EXT  8'h35
`define OP_WR_MULT     8'hC5
`define OP_WR_MULT_EXT 8'h39
`define OP_WR_SECT     8'h30
`define OP_WR_SECT_EXT 8'h34
`define OP_WR_NOERASE  8'h38
`define OP_WR_VERIFY   8'h3C
`define OP_SET_MULT    8'hC6
`define OP_SET_MAX     8'hF9
`define SPB_RESET      8'h01
`define MAX_LBA_RESET  48'hFFFFFFFFFFFF
`define WORDS_PER_SECT 8'hFF
`define ERR_IDNF       8'h10
`define ERR_ABRT       8'h04
`endif

// *** design/wcmd_pkg.sv ***
// Purpose: Types for the write-family command decoder.
// Assumes: Used by package-qualified name only.
// Notes:   Protocol and state enumerations.
package wcmd_pkg;
	typedef enum logic [1:0] {
		PROTO_NONE = 2'b00,
		PROTO_PIO  = 2'b01,
		PROTO_DMA  = 2'b10
	} proto_type;
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_XFER   = 3'b001,
		ST_VERIFY = 3'b010,
		ST_DONE   = 3'b011,
		ST_ERROR  = 3'b100
	} state_type;
endpackage

// *** design/ata_write_command_decoder.sv ***
// Purpose: Decode and run the write-family commands of the storage device.
// Assumes: Commands and data words are synchronous to core_clk.
// Notes:   Data passes through a two-entry buffer toward the media side.
//
// What this block does
// - CAh/CBh: DMA write, 8-bit count, zero=256
// - 35h: DMA write, 16-bit count, zero=65536
// - C5h: interrupt once per completed block
// - 39h: block interrupts, extended count and address
// - 30h: 1 to 256 sectors, zero=256
// - 34h: 1 to 65536 sectors, zero=65536
// - 38h: same as plain sector write
// - 3Ch: verify every sector before completion
// - Start at given address, then consecutive sectors
// - Block size set only by C6h
// - Beyond maximum address: reject with ID-not-found
`timescale 1ns/100ps
`include "wcmd_consts.svh"

module ata_write_command_decoder (
	// Clock, reset and enable.
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic        clk_en,
	// Command from the host controller.
	input  wire logic        cmd_valid,
	input  wire logic [7:0]  cmd_opcode,
	input  wire logic [15:0] cmd_count,
	input  wire logic [47:0] cmd_lba,
	// Incoming data words from the host.
	input  wire logic        in_valid,
	output logic             in_ready,
	input  wire logic [15:0] in_data,
	// Outgoing data words toward the media.
	output logic             out_valid,
	input  wire logic        out_ready,
	output logic [15:0]      out_data,
	output logic [47:0]      out_lba,
	// Verify handshake with the media.
	output logic             verify_req,
	input  wire logic        verify_ok,
	// Status toward the host.
	output logic             busy,
	output logic             irq,
	output logic             cmd_error,
	output logic [7:0]       error_code,
	output wcmd_pkg::proto_type proto,
	output logic [16:0]      sect_left
);

	// -----------------------------------------------------------------
	// Command decoding
	// -----------------------------------------------------------------
	wire is_dma_short = cmd_opcode == `OP_WR_DMA_A || cmd_opcode == `OP_WR_DMA_B;
	wire is_dma_ext   = cmd_opcode == `OP_WR_DMA_EXT;
	wire is_mult      = cmd_opcode == `OP_WR_MULT;
	wire is_mult_ext  = cmd_opcode == `OP_WR_MULT_EXT;
	wire is_sect      = cmd_opcode == `OP_WR_SECT || cmd_opcode == `OP_WR_NOERASE;
	wire is_sect_ext  = cmd_opcode == `OP_WR_SECT_EXT;
	wire is_vfy       = cmd_opcode == `OP_WR_VERIFY;
	wire is_ext       = is_dma_ext | is_mult_ext | is_sect_ext;
	wire is_write     = is_dma_short | is_ext | is_mult | is_sect | is_vfy;
	wire is_dma       = is_dma_short | is_dma_ext;
	wire is_multi_any = is_mult | is_mult_ext;

	// Zero count means the full range of the field width.
	function automatic logic [16:0] expand_count(input logic [15:0] raw, input logic ext);
		logic [16:0] n;
		n = ext ? {1'b0, raw} : {9'h000, raw[7:0]};
		if (n == 17'h00000) begin
			n = ext ? 17'h10000 : 17'h00100;
		end
		return n;
	endfunction

	wire [16:0] next_count = expand_count(cmd_count, is_ext);
	// Short commands carry only a 28-bit address.
	wire [47:0] start_lba  = is_ext ? cmd_lba : {20'h00000, cmd_lba[27:0]};
	wire [47:0] last_lba   = start_lba + {31'h00000000, next_count} - 48'h000000000001;

	// -----------------------------------------------------------------
	// State
	// -----------------------------------------------------------------
	wcmd_pkg::state_type state;
	logic [7:0]  spb;        // Sectors per block for multiple writes.
	logic [47:0] max_lba;    // Highest accepted address.
	logic        multi;      // Current command interrupts per block.
	logic        verify;     // Current command verifies sectors.
	logic [7:0]  word_cnt;   // Word index within a sector.
	logic [7:0]  blk_cnt;    // Sectors completed in current block.
	logic [47:0] cur_lba;    // Address of sector being written.

	// Two-entry buffer, flip-flop storage indexed by pointer.
	logic [15:0] buf_mem [0:1];
	logic        wr_ptr;
	logic        rd_ptr;
	logic [1:0]  fill;

	wire accept = clk_en && cmd_valid && state == wcmd_pkg::ST_IDLE;
	wire in_xfer = state == wcmd_pkg::ST_XFER;
	assign in_ready  = in_xfer && fill != 2'h2;
	assign out_valid = in_xfer && fill != 2'h0; // Words wait while a sector verifies.
	assign out_data  = buf_mem[rd_ptr];
	wire push = clk_en && in_valid && in_ready;
	wire pop  = clk_en && out_valid && out_ready;
	wire sect_end  = pop && word_cnt == `WORDS_PER_SECT;
	wire last_sect = sect_left == 17'h00001;
	wire blk_end   = blk_cnt == spb - 8'h01;
	assign busy = state != wcmd_pkg::ST_IDLE;

	// Buffer pointers and fill level.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			fill   <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr <= ~wr_ptr;
			end
			if (pop) begin
				rd_ptr <= ~rd_ptr;
			end
			fill <= fill + {1'b0, push} - {1'b0, pop};
		end
	end

	// Buffer storage holds no control, so it needs no reset.
	always_ff @(posedge core_clk) begin
		if (push) begin
			buf_mem[wr_ptr] <= in_data;
		end
	end

	// Block size and maximum address registers, changed only by set-multiple and set-max.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			spb     <= `SPB_RESET;
			max_lba <= `MAX_LBA_RESET;
		end else if (accept && cmd_opcode == `OP_SET_MULT && cmd_count[7:0] != 8'h00) begin
			spb <= cmd_count[7:0];
		end else if (accept && cmd_opcode == `OP_SET_MAX) begin
			max_lba <= cmd_lba;
		end
	end

	// Main command sequencer; interrupts are pulses that last one enabled cycle.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state      <= wcmd_pkg::ST_IDLE;
			multi      <= 1'b0;
			verify     <= 1'b0;
			word_cnt   <= 8'h00;
			blk_cnt    <= 8'h00;
			cur_lba    <= 48'h000000000000;
			out_lba    <= 48'h000000000000;
			sect_left  <= 17'h00000;
			irq        <= 1'b0;
			cmd_error  <= 1'b0;
			error_code <= 8'h00;
			proto      <= wcmd_pkg::PROTO_NONE;
			verify_req <= 1'b0;
		end else if (clk_en) begin
			irq <= 1'b0;
			case (state)
				wcmd_pkg::ST_IDLE: begin
					if (accept && is_write) begin
						cmd_error <= 1'b0;
						error_code <= 8'h00;
						if (last_lba > max_lba) begin
							state <= wcmd_pkg::ST_ERROR;
						end else begin
							state     <= wcmd_pkg::ST_XFER;
							cur_lba   <= start_lba;
							out_lba   <= start_lba;
							sect_left <= next_count;
							multi     <= is_multi_any;
							verify    <= is_vfy;
							proto     <= is_dma ? wcmd_pkg::PROTO_DMA : wcmd_pkg::PROTO_PIO;
							word_cnt  <= 8'h00;
							blk_cnt   <= 8'h00;
						end
					end else if (accept && cmd_valid) begin
						// Non-write commands complete at once without data.
						irq <= 1'b1;
					end
				end
				wcmd_pkg::ST_XFER: begin
					if (pop) begin
						word_cnt <= word_cnt + 8'h01;
					end
					if (sect_end) begin
						cur_lba <= cur_lba + 48'h000000000001;
						out_lba <= cur_lba + 48'h000000000001;
						sect_left <= sect_left - 17'h00001;
						blk_cnt <= blk_end ? 8'h00 : blk_cnt + 8'h01;
						if (verify) begin
							state      <= wcmd_pkg::ST_VERIFY;
							verify_req <= 1'b1;
						end else if (last_sect) begin
							state <= wcmd_pkg::ST_DONE;
						end else if (proto == wcmd_pkg::PROTO_PIO) begin
							// Multiple writes pulse per block, plain writes per sector.
							irq <= multi ? blk_end : 1'b1;
						end
					end
				end
				wcmd_pkg::ST_VERIFY: begin
					if (verify_ok) begin
						verify_req <= 1'b0;
						if (sect_left == 17'h00000) begin
							state <= wcmd_pkg::ST_DONE;
						end else begin
							state <= wcmd_pkg::ST_XFER;
							irq   <= proto == wcmd_pkg::PROTO_PIO;
						end
					end
				end
				wcmd_pkg::ST_DONE: begin
					irq   <= 1'b1;
					proto <= wcmd_pkg::PROTO_NONE;
					state <= wcmd_pkg::ST_IDLE;
				end
				wcmd_pkg::ST_ERROR: begin
					irq        <= 1'b1;
					cmd_error  <= 1'b1;
					error_code <= `ERR_IDNF;
					state      <= wcmd_pkg::ST_IDLE;
				end
				default: begin
					state <= wcmd_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------
	property p_busy_after_write;
		@(posedge core_clk) disable iff (!arst_n)
		accept && is_write |=> busy;
	endproperty
	a_busy_after_write: assert property (p_busy_after_write) else $error("Busy not raised.");

	property p_dma_count;
		@(posedge core_clk) disable iff (!arst_n)
		accept && is_dma_short && cmd_count[7:0] == 8'h00 && last_lba <= max_lba
		|=> sect_left == 17'h00100;
	endproperty
	a_dma_count: assert property (p_dma_count) else $error("Zero count not 256.");

	property p_ext_count;
		@(posedge core_clk) disable iff (!arst_n)
		accept && is_ext && cmd_count == 16'h0000 && last_lba <= max_lba
		|=> sect_left == 17'h10000;
	endproperty
	a_ext_count: assert property (p_ext_count) else $error("Zero ext count wrong.");

	property p_start_lba;
		@(posedge core_clk) disable iff (!arst_n)
		accept && is_write && last_lba <= max_lba |=> out_lba == $past(start_lba);
	endproperty
	a_start_lba: assert property (p_start_lba) else $error("Start address wrong.");

	property p_idnf;
		@(posedge core_clk) disable iff (!arst_n)
		accept && is_write && last_lba > max_lba |-> ##[1:3] (cmd_error && error_code == `ERR_IDNF);
	endproperty
	a_idnf: assert property (p_idnf) else $error("Out of range not rejected.");

	property p_spb_stable;
		@(posedge core_clk) disable iff (!arst_n)
		!(accept && cmd_opcode == `OP_SET_MULT) |=> $stable(spb);
	endproperty
	a_spb_stable: assert property (p_spb_stable) else $error("Block size changed.");

	property p_mult_irq;
		@(posedge core_clk) disable iff (!arst_n)
		state == wcmd_pkg::ST_XFER && multi && !verify && sect_end && !last_sect && !blk_end
		|=> !irq;
	endproperty
	a_mult_irq: assert property (p_mult_irq) else $error("Mid-block interrupt.");

	property p_verify_first;
		@(posedge core_clk) disable iff (!arst_n)
		state == wcmd_pkg::ST_XFER && verify && sect_end |=> state == wcmd_pkg::ST_VERIFY;
	endproperty
	a_verify_first: assert property (p_verify_first) else $error("Verify skipped.");

	property p_pio_proto;
		@(posedge core_clk) disable iff (!arst_n)
		accept && (is_sect || is_sect_ext) && last_lba <= max_lba |=> proto == wcmd_pkg::PROTO_PIO;
	endproperty
	a_pio_proto: assert property (p_pio_proto) else $error("Wrong protocol.");

endmodule

// *** bench/media_model.sv ***
// Purpose: Media side that drains data words and answers verify requests.
// Assumes: Words arrive in sector order, numbered by a free-running count.
// Notes:   Stalls one cycle in three so the two-entry buffer fills.
`timescale 1ns/100ps
module media_model (
	// Clock and reset.
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	// Word stream from the decoder.
	input  wire logic        out_valid,
	output logic             out_ready,
	input  wire logic [15:0] out_data,
	input  wire logic [47:0] out_lba,
	// Verify handshake.
	input  wire logic        verify_req,
	output logic             verify_ok,
	// Observation for the bench.
	output int               pops,
	output int               bad_words,
	output int               verifies,
	output logic [47:0]      last_lba
);
	int tick; // Stall pacer.
	initial begin
		tick = 0;
		out_ready = 0;
		verify_ok = 0;
		pops = 0;
		bad_words = 0;
		verifies = 0;
		last_lba = '0;
	end
	// Take words in order; answer verify only on odd ticks so the wait is real.
	always @(posedge core_clk) begin
		tick <= tick + 1;
		if (out_valid === 1'b1 && out_ready) begin
			if (out_data !== pops[15:0])
				bad_words <= bad_words + 1;
			pops <= pops + 1;
			last_lba <= out_lba;
		end
		out_ready <= #1 (tick % 3 != 2);
		verify_ok <= #1 arst_n && (verify_req === 1'b1) && !verify_ok && tick[0];
		if (verify_req === 1'b1 && verify_ok)
			verifies <= verifies + 1;
	end
endmodule

// *** bench/ata_write_command_decoder_tb.sv ***
// Purpose: Self-checking bench for the write-family command decoder.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Table rows run whole commands; zero counts and range faults follow.
`timescale 1ns/100ps
`include "wcmd_consts.svh"
module ata_write_command_decoder_tb;
	logic core_clk = 0, arst_n = 0, cmd_valid = 0, in_valid = 0, clk_en = 1;
	logic [7:0] cmd_opcode = '0;
	logic [15:0] cmd_count = '0, in_data = '0, out_data;
	logic [47:0] cmd_lba = '0, out_lba, last_lba;
	logic in_ready, out_valid, out_ready, verify_req, verify_ok;
	logic busy, irq, cmd_error;
	logic [7:0] error_code;
	wcmd_pkg::proto_type proto;
	logic [16:0] sect_left;
	int failures = 0, compares = 0, words = 0, nirq, pops, bad_words, verifies;
	typedef struct {logic [7:0] op; logic [15:0] cnt; logic [47:0] lba;
		wcmd_pkg::proto_type pr; int irqs; int vers;} row_type;
	localparam wcmd_pkg::proto_type PIO = wcmd_pkg::PROTO_PIO;
	localparam wcmd_pkg::proto_type DMA = wcmd_pkg::PROTO_DMA;
	row_type rows [9] = '{
		'{`OP_WR_SECT, 16'h0001, 48'h100, PIO, 1, 0},
		'{`OP_WR_SECT_EXT, 16'h0002, 48'h1000000000, PIO, 2, 0},
		'{`OP_WR_NOERASE, 16'h0001, 48'h7, PIO, 1, 0},
		'{`OP_WR_VERIFY, 16'h0002, 48'h20, PIO, 2, 2},
		'{`OP_WR_DMA_A, 16'h0001, 48'h30, DMA, 1, 0},
		'{`OP_WR_DMA_B, 16'h0002, 48'h40, DMA, 1, 0},
		'{`OP_WR_DMA_EXT, 16'h0001, 48'h2000000000, DMA, 1, 0},
		'{`OP_WR_MULT, 16'h0004, 48'h50, PIO, 2, 0},
		'{`OP_WR_MULT_EXT, 16'h0002, 48'h3000000000, PIO, 1, 0}};
	logic [7:0] zops [5] = '{`OP_WR_SECT, `OP_WR_NOERASE, `OP_WR_DMA_A, `OP_WR_SECT_EXT,
		`OP_WR_DMA_EXT};
	logic [16:0] zexp [5] = '{17'h100, 17'h100, 17'h100, 17'h10000, 17'h10000};
	ata_write_command_decoder dut_u (.core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en),
		.cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .cmd_count(cmd_count),
		.cmd_lba(cmd_lba), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
		.out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
		.out_lba(out_lba), .verify_req(verify_req), .verify_ok(verify_ok), .busy(busy),
		.irq(irq), .cmd_error(cmd_error), .error_code(error_code), .proto(proto),
		.sect_left(sect_left));
	media_model media_u (.core_clk(core_clk), .arst_n(arst_n), .out_valid(out_valid),
		.out_ready(out_ready), .out_data(out_data), .out_lba(out_lba),
		.verify_req(verify_req), .verify_ok(verify_ok), .pops(pops),
		.bad_words(bad_words), .verifies(verifies), .last_lba(last_lba));
	// Free-running clock and interrupt pulse counter.
	always #4 core_clk = ~core_clk;
	always @(posedge core_clk) if (irq === 1'b1) nirq++;
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		if (failures == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// A command is held for one edge; the design takes it while idle.
	// A spare edge follows, so two commands in a row never drop and raise
	// the request within one time step.
	task automatic issue(input logic [7:0] op, input logic [15:0] cnt, input logic [47:0] lba);
		cmd_opcode = op;
		cmd_count = cnt;
		cmd_lba = lba;
		cmd_valid = 1;
		@(posedge core_clk) #1;
		cmd_valid = 0;
		@(posedge core_clk) #1;
	endtask
	// Busy falls at the edge that raises the closing interrupt; one more edge
	// lets the pulse counter see that pulse before the count is compared.
	task automatic wait_idle;
		for (int k = 0; k < 60 && busy !== 1'b0; k++) @(posedge core_clk) #1;
		chk(busy, 0);
		chk(irq, 1);
		@(posedge core_clk) #1;
	endtask
	task automatic run(input row_type r);
		int w;
		int v0;
		logic ok;
		w = 0;
		v0 = verifies;
		issue(r.op, r.cnt, r.lba);
		// Pulses counted up to here belong to earlier commands.
		nirq = 0;
		chk(busy, 1);
		chk(proto, r.pr);
		chk(sect_left, r.cnt);
		chk(out_lba, r.lba);
		in_valid = 1;
		while (w < r.cnt * 256) begin
			in_data = words[15:0];
			ok = in_ready;
			@(posedge core_clk) #1;
			if (ok === 1'b1) begin
				w++;
				words++;
			end
		end
		in_valid = 0;
		wait_idle();
		chk(nirq, r.irqs);
		chk(verifies - v0, r.vers);
		chk(last_lba, r.lba + r.cnt - 1);
	endtask
	initial begin
		#200000;
		failures++;
		tally_and_finish();
	end
	initial begin
		repeat (2) @(posedge core_clk);
		#1 arst_n = 1;
		issue(`OP_SET_MULT, 16'h0002, '0);
		issue(`OP_SET_MULT, 16'h0000, '0);
		foreach (rows[i]) run(rows[i]);
		chk(bad_words, 0);
		chk(pops, words);
		// Zero counts mean the full range; reset clears the command.
		foreach (zops[i]) begin
			issue(zops[i], 16'h0000, '0);
			chk(sect_left, zexp[i]);
			arst_n = 0;
			@(posedge core_clk) #1;
			chk(busy, 0);
			chk(proto, wcmd_pkg::PROTO_NONE);
			arst_n = 1;
		end
		// With the enable low a request is not taken and nothing moves.
		nirq = 0;
		clk_en = 0;
		issue(`OP_WR_SECT, 16'h0001, '0);
		chk(busy, 0);
		chk(nirq, 0);
		clk_en = 1;
		// A write past the set maximum is refused; one ending on it is not.
		nirq = 0;
		issue(`OP_SET_MAX, 16'h0000, 48'h10);
		chk(nirq, 1);
		issue(`OP_WR_SECT, 16'h0002, 48'h10);
		repeat (3) if (cmd_error !== 1'b1) @(posedge core_clk) #1;
		chk(cmd_error, 1);
		chk(error_code, `ERR_IDNF);
		wait_idle();
		run('{`OP_WR_SECT, 16'h0001, 48'h10, PIO, 1, 0});
		chk(cmd_error, 0);
		tally_and_finish();
	end
endmodule
